/* File: logic/tsc_defs.svh */
`ifndef TSC_DEFS_SVH
`define TSC_DEFS_SVH

`define TSC_CLK_MHZ       100
`define TSC_CLIENT_ADDR   7'h28
`define TSC_BYTE_BITS     8
`define TSC_SCL_LOW_MS    30
`define TSC_IDLE_US       200
`define TSC_FSCL_MAX_KHZ  400
`define TSC_FSCL_MIN_KHZ  10

`endif

/* File: logic/tsc_pkg.sv */
package tsc_pkg;

	typedef enum logic [2:0] {
		D_IDLE   = 3'b000,
		D_ADDR   = 3'b001,
		D_REG    = 3'b010,
		D_WDATA  = 3'b011,
		D_RDATA  = 3'b100,
		D_IGNORE = 3'b101
	} tsc_dev_state_type;

	typedef enum logic [1:0] {
		H_IDLE  = 2'b00,
		H_START = 2'b01,
		H_BIT   = 2'b10,
		H_STOP  = 2'b11
	} tsc_host_state_type;

	typedef enum logic [1:0] {
		K_WRITE = 2'b00,
		K_SEND  = 2'b01,
		K_READ  = 2'b10,
		K_RECV  = 2'b11
	} tsc_kind_type;

	typedef enum logic [2:0] {
		S_ADDR_W = 3'b000,
		S_REG    = 3'b001,
		S_WDATA  = 3'b010,
		S_ADDR_R = 3'b011,
		S_RDATA  = 3'b100
	} tsc_step_type;

endpackage : tsc_pkg

/* File: logic/tsc_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface tsc_link_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// wired-and of the open-drain drivers, pulled up when nobody pulls low
	assign scl = ~(host_scl_oe & ~host_scl_o);
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

	modport host (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, input scl, sda);
	modport dev  (output dev_sda_o, dev_sda_oe, input scl, sda);
endinterface : tsc_link_if
`default_nettype wire

/* File: logic/tsc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module tsc_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             clk_i,
	input  wire logic             resetn_i,
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta;

	// lines idle high, so reset to ones to avoid a false start edge
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta <= '1;
			q_o  <= '1;
		end else begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule : tsc_sync
`default_nettype wire

/* File: logic/tsc_client.sv */
// Notes on behaviour
// - first byte: 7-bit address, then direction
// - answer only to fixed client address
// - bytes are eight bits, msb first
// - acknowledge every received byte after bit eight
// - host acks read bytes except last
// - stop resets client state, ready again
// - enabled timeout: clock low 30 ms resets
// - timeouts off at reset, enable bit only
// - enabled idle: both high 200 us resets
// - host clocks between 10 and 400 kHz
// - no byte-count byte, any length
// - no alert response address
// - single write: pointer, data, stored there
// - single read: pointer, restart, one byte
// - pointer-only write loads pointer, no data
// - read without pointer returns current register
// - deep sleep may break pointer-only forms
// - block read continues until host nack
// - read pointer advances, wraps ff to 00
// - never stretch the clock
// - block write stores, advances, wraps
// - addressed traffic wakes, sleep bit kept
`include "tsc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tsc_client
	import tsc_pkg::*;
#(
	parameter int unsigned LOW_CYCLES  = `TSC_SCL_LOW_MS * 1000 * `TSC_CLK_MHZ,
	parameter int unsigned IDLE_CYCLES = `TSC_IDLE_US * `TSC_CLK_MHZ,
	parameter logic [6:0]  CLIENT_ADDR = `TSC_CLIENT_ADDR
) (
	input  wire logic       core_clk_i,
	input  wire logic       resetn_i,
	tsc_link_if.dev         link,
	input  wire logic       timeout_en_i,
	input  wire logic       deepest_sleep_control_i,
	input  wire logic [7:0] rd_data_i,
	output logic      [7:0] rd_ptr_o,
	output logic            wr_strobe_o,
	output logic      [7:0] wr_addr_o,
	output logic      [7:0] wr_data_o,
	output logic            awake_o
);
	localparam int unsigned LW = $clog2(LOW_CYCLES + 1);
	localparam int unsigned IW = $clog2(IDLE_CYCLES + 1);
	localparam logic [3:0]  LAST_BIT = 4'(`TSC_BYTE_BITS);
	localparam logic [3:0]  ACK_BIT  = 4'(`TSC_BYTE_BITS + 1);

	tsc_dev_state_type state;
	logic              scl_s;
	logic              sda_s;
	logic              scl_d;
	logic              sda_d;
	logic              rise;
	logic              fall;
	logic              start_c;
	logic              stop_c;
	logic [LW-1:0]     low_cnt;
	logic [IW-1:0]     idle_cnt;
	logic              low_tout;
	logic              idle_tout;
	logic              bus_reset;
	logic [3:0]        bitcnt;
	logic [7:0]        shreg;
	logic [7:0]        tx;
	logic              ack_slot;
	logic              host_ack;

	////////////////////////////////////////////////////////////////////////
	// pin sampling and condition detection
	// the clock line is only ever read here: this end has no clock driver
	tsc_sync #(
		.WIDTH (2)
	) u_sync (
		.clk_i    (core_clk_i),
		.resetn_i (resetn_i),
		.d_i      ({link.scl, link.sda}),
		.q_o      ({scl_s, sda_s})
	);

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	assign rise    = scl_s & ~scl_d;
	assign fall    = ~scl_s & scl_d;
	assign start_c = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_c  = scl_s & scl_d & ~sda_d & sda_s;

	////////////////////////////////////////////////////////////////////////
	// bus timeouts; a low enable holds both counters cleared
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			low_cnt  <= '0;
			low_tout <= 1'b0;
		end else begin
			low_tout <= 1'b0;
			if (!timeout_en_i || scl_s) begin
				low_cnt <= '0;
			end else if (low_cnt == LW'(LOW_CYCLES - 1)) begin
				low_cnt  <= '0;
				low_tout <= 1'b1;
			end else begin
				low_cnt <= low_cnt + 1'b1;
			end
		end
	end

	// fires once per idle stretch, after more than the idle time
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			idle_cnt  <= '0;
			idle_tout <= 1'b0;
		end else begin
			idle_tout <= 1'b0;
			if (!timeout_en_i || !(scl_s && sda_s)) begin
				idle_cnt <= '0;
			end else if (idle_cnt != IW'(IDLE_CYCLES)) begin
				idle_cnt <= idle_cnt + 1'b1;
				if (idle_cnt == IW'(IDLE_CYCLES - 1)) begin
					idle_tout <= 1'b1;
				end
			end
		end
	end

	assign bus_reset = stop_c | low_tout | idle_tout;

	////////////////////////////////////////////////////////////////////////
	// protocol engine
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state           <= D_IDLE;
			bitcnt          <= 4'h0;
			shreg           <= 8'h00;
			tx              <= 8'h00;
			ack_slot        <= 1'b0;
			host_ack        <= 1'b0;
			link.dev_sda_oe <= 1'b0;
			rd_ptr_o        <= 8'h00;
			wr_strobe_o     <= 1'b0;
			wr_addr_o       <= 8'h00;
			wr_data_o       <= 8'h00;
		end else begin
			wr_strobe_o <= 1'b0;
			if (bus_reset) begin
				state           <= D_IDLE;
				ack_slot        <= 1'b0;
				link.dev_sda_oe <= 1'b0;
			end else if (start_c) begin
				// a repeated start keeps the pointer, so a read follows the written address
				state           <= D_ADDR;
				bitcnt          <= 4'h0;
				ack_slot        <= 1'b0;
				link.dev_sda_oe <= 1'b0;
			end else begin
				case (state)
					D_ADDR, D_REG, D_WDATA: begin
						if (rise && !ack_slot) begin
							shreg  <= {shreg[6:0], sda_s};
							bitcnt <= bitcnt + 4'h1;
						end else if (fall && ack_slot) begin
							ack_slot        <= 1'b0;
							link.dev_sda_oe <= 1'b0;
							bitcnt          <= 4'h0;
						end else if (fall && bitcnt == LAST_BIT) begin
							ack_slot        <= 1'b1;
							link.dev_sda_oe <= 1'b1;
							case (state)
								D_ADDR: begin
									// only the own address matches; the alert address is not answered
									if (shreg[7:1] == CLIENT_ADDR) begin
										state <= shreg[0] ? D_RDATA : D_REG;
									end else begin
										ack_slot        <= 1'b0;
										link.dev_sda_oe <= 1'b0;
										state           <= D_IGNORE;
									end
								end
								D_REG: begin
									// a stop after this byte leaves just the pointer loaded
									rd_ptr_o <= shreg;
									state    <= D_WDATA;
								end
								default: begin
									// every further byte is data, no length byte expected
									wr_strobe_o <= 1'b1;
									wr_addr_o   <= rd_ptr_o;
									wr_data_o   <= shreg;
									rd_ptr_o    <= rd_ptr_o + 8'h01;
								end
							endcase
						end
					end
					D_RDATA: begin
						if (fall && (ack_slot || (bitcnt == ACK_BIT && host_ack))) begin
							// the byte at the current pointer goes out, msb first
							ack_slot        <= 1'b0;
							link.dev_sda_oe <= ~rd_data_i[7];
							tx              <= {rd_data_i[6:0], 1'b0};
							bitcnt          <= 4'h1;
						end else if (fall && bitcnt == ACK_BIT) begin
							state <= D_IGNORE;
						end else if (fall && bitcnt == LAST_BIT) begin
							link.dev_sda_oe <= 1'b0;
							bitcnt          <= ACK_BIT;
						end else if (fall) begin
							link.dev_sda_oe <= ~tx[7];
							tx              <= {tx[6:0], 1'b0};
							bitcnt          <= bitcnt + 4'h1;
						end else if (rise && bitcnt == ACK_BIT) begin
							host_ack <= ~sda_s;
							// advance only on ack, so a closing nack leaves the pointer for repeat reads
							if (!sda_s) begin
								rd_ptr_o <= rd_ptr_o + 8'h01;
							end
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin value and wake request
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			link.dev_sda_o <= 1'b0;
		end else begin
			link.dev_sda_o <= 1'b0;
		end
	end

	// the sleep bit is only read, never cleared; pointer-only forms still work asleep
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			awake_o <= 1'b0;
		end else begin
			awake_o <= deepest_sleep_control_i &&
				(state == D_REG || state == D_WDATA || state == D_RDATA);
		end
	end
endmodule : tsc_client
`default_nettype wire

/* File: logic/tsc_host.sv */
`include "tsc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tsc_host
	import tsc_pkg::*;
#(
	// rounded up so the bus never runs above its top rate; keep below the slowest rate too
	parameter int unsigned QUARTER_CYCLES =
		(`TSC_CLK_MHZ * 1000 + 4 * `TSC_FSCL_MAX_KHZ - 1) / (4 * `TSC_FSCL_MAX_KHZ),
	parameter logic [6:0]  CLIENT_ADDR    = `TSC_CLIENT_ADDR
) (
	input  wire logic         core_clk_i,
	input  wire logic         resetn_i,
	tsc_link_if.host          link,
	input  wire logic         cmd_valid_i,
	output logic              cmd_ready_o,
	input  wire tsc_kind_type cmd_kind_i,
	input  wire logic [7:0]   cmd_reg_i,
	input  wire logic [7:0]   cmd_count_i,
	input  wire logic [7:0]   wr_data_i,
	output logic              wr_take_o,
	output logic      [7:0]   rd_data_o,
	output logic              rd_valid_o,
	output logic              done_o,
	output logic              nack_o
);
	localparam int unsigned QW = $clog2(QUARTER_CYCLES + 1);

	tsc_host_state_type hstate;
	tsc_step_type       step;
	tsc_kind_type       kind;
	logic [QW-1:0]      qcnt;
	logic               tick;
	logic [1:0]         q;
	logic [3:0]         bit_i;
	logic [8:0]         shift;
	logic [8:0]         rx;
	logic [7:0]         reg_addr;
	logic [7:0]         cnt;
	logic               sda_s;

	// write frames release the ninth bit for the ack; read frames release all eight data bits
	function automatic logic [8:0] tsc_frame(input logic [7:0] b, input logic rd, input logic last);
		return rd ? {8'hFF, last} : {b, 1'b1};
	endfunction : tsc_frame

	tsc_sync #(
		.WIDTH (1)
	) u_sync (
		.clk_i    (core_clk_i),
		.resetn_i (resetn_i),
		.d_i      (link.sda),
		.q_o      (sda_s)
	);

	////////////////////////////////////////////////////////////////////////
	// clock divider: four quarters per bit
	assign tick = (qcnt == QW'(QUARTER_CYCLES - 1));

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			qcnt <= '0;
		end else if (hstate == H_IDLE || tick) begin
			qcnt <= '0;
		end else begin
			qcnt <= qcnt + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hstate           <= H_IDLE;
			step             <= S_ADDR_W;
			kind             <= K_WRITE;
			q                <= 2'h0;
			bit_i            <= 4'h0;
			shift            <= 9'h1FF;
			rx               <= 9'h000;
			reg_addr         <= 8'h00;
			cnt              <= 8'h00;
			link.host_scl_oe <= 1'b0;
			link.host_sda_oe <= 1'b0;
			link.host_scl_o  <= 1'b0;
			link.host_sda_o  <= 1'b0;
			cmd_ready_o      <= 1'b1;
			wr_take_o        <= 1'b0;
			rd_data_o        <= 8'h00;
			rd_valid_o       <= 1'b0;
			done_o           <= 1'b0;
			nack_o           <= 1'b0;
		end else begin
			wr_take_o  <= 1'b0;
			rd_valid_o <= 1'b0;
			done_o     <= 1'b0;
			case (hstate)
				H_IDLE: begin
					if (cmd_valid_i && cmd_ready_o) begin
						kind        <= cmd_kind_i;
						reg_addr    <= cmd_reg_i;
						cnt         <= cmd_count_i;
						cmd_ready_o <= 1'b0;
						nack_o      <= 1'b0;
						step        <= (cmd_kind_i == K_RECV) ? S_ADDR_R : S_ADDR_W;
						q           <= 2'h0;
						hstate      <= H_START;
					end
				end
				H_START: if (tick) begin
					q <= q + 2'h1;
					case (q)
						2'h0: link.host_sda_oe <= 1'b0;
						2'h1: link.host_scl_oe <= 1'b0;
						2'h2: link.host_sda_oe <= 1'b1;
						default: begin
							link.host_scl_oe <= 1'b1;
							shift  <= tsc_frame({CLIENT_ADDR, step == S_ADDR_R}, 1'b0, 1'b0);
							bit_i  <= 4'h0;
							hstate <= H_BIT;
						end
					endcase
				end
				H_BIT: if (tick) begin
					q <= q + 2'h1;
					case (q)
						2'h0: link.host_sda_oe <= ~shift[8];
						2'h1: link.host_scl_oe <= 1'b0;
						2'h2: rx <= {rx[7:0], sda_s};
						default: begin
							link.host_scl_oe <= 1'b1;
							shift <= {shift[7:0], 1'b1};
							bit_i <= bit_i + 4'h1;
							if (bit_i == 4'(`TSC_BYTE_BITS)) begin
								bit_i <= 4'h0;
								case (step)
									S_ADDR_W: if (rx[0]) begin
										nack_o <= 1'b1;
										hstate <= H_STOP;
									end else begin
										step  <= S_REG;
										shift <= tsc_frame(reg_addr, 1'b0, 1'b0);
									end
									S_REG: if (rx[0]) begin
										nack_o <= 1'b1;
										hstate <= H_STOP;
									end else if (kind == K_SEND) begin
										hstate <= H_STOP;
									end else if (kind == K_READ) begin
										step   <= S_ADDR_R;
										hstate <= H_START;
									end else begin
										step      <= S_WDATA;
										shift     <= tsc_frame(wr_data_i, 1'b0, 1'b0);
										wr_take_o <= 1'b1;
									end
									S_WDATA: begin
										cnt <= cnt - 8'h01;
										if (rx[0]) begin
											nack_o <= 1'b1;
											hstate <= H_STOP;
										end else if (cnt == 8'h01) begin
											hstate <= H_STOP;
										end else begin
											// plain byte stream, no count byte
											shift     <= tsc_frame(wr_data_i, 1'b0, 1'b0);
											wr_take_o <= 1'b1;
										end
									end
									S_ADDR_R: if (rx[0]) begin
										nack_o <= 1'b1;
										hstate <= H_STOP;
									end else begin
										step  <= S_RDATA;
										shift <= tsc_frame(8'h00, 1'b1, cnt == 8'h01);
									end
									default: begin
										rd_data_o  <= rx[8:1];
										rd_valid_o <= 1'b1;
										cnt        <= cnt - 8'h01;
										if (cnt == 8'h01) begin
											hstate <= H_STOP;
										end else begin
											shift <= tsc_frame(8'h00, 1'b1, cnt == 8'h02);
										end
									end
								endcase
							end
						end
					endcase
				end
				default: if (tick) begin
					q <= q + 2'h1;
					case (q)
						2'h0: link.host_sda_oe <= 1'b1;
						2'h1: link.host_scl_oe <= 1'b0;
						2'h2: link.host_sda_oe <= 1'b0;
						default: begin
							done_o      <= 1'b1;
							cmd_ready_o <= 1'b1;
							hstate      <= H_IDLE;
						end
					endcase
				end
			endcase
		end
	end
endmodule : tsc_host
`default_nettype wire

/* File: verif/tsc_link_props.sv */
`timescale 1ns/1ps
`default_nettype none
module tsc_link_props
	import tsc_pkg::*;
#(
	parameter logic [6:0] CLIENT_ADDR = 7'h28
) (
	input  wire logic core_clk_i,
	input  wire logic resetn_i,
	input  wire logic dev_sda_oe,
	input  wire logic scl,
	input  wire logic sda
);
	logic       scl_q;
	logic       sda_q;
	logic       in_frame;
	logic       rd_dir;
	logic [3:0] bit_n;
	logic [1:0] byte_n;
	logic [7:0] shift;
	logic       start_ev;
	logic       stop_ev;
	logic       rise_ev;
	logic       fall_ev;
	logic       dev_rx;
	logic [8:0] per_cnt;

	////////////////////////////////////////////////////////////////////////////////
	assign start_ev = scl & scl_q & sda_q & ~sda;
	assign stop_ev  = scl & scl_q & ~sda_q & sda;
	assign rise_ev  = scl & ~scl_q & in_frame;
	assign fall_ev  = ~scl & scl_q & in_frame;
	// bytes the client takes in: a matching address byte, then every byte of a write frame
	assign dev_rx   = (byte_n == 2'h0) ? (shift[7:1] == CLIENT_ADDR) : ~rd_dir;

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
		end
	end

	// cycles since the last clock rise in a frame; saturates so a long gap never wraps to a short one
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			per_cnt <= 9'h000;
		end else if (rise_ev) begin
			per_cnt <= 9'h001;
		end else if (per_cnt != 9'h000 && per_cnt != 9'h1ff) begin
			per_cnt <= per_cnt + 9'h001;
		end
	end

	// byte counter saturates: only the first bytes of a frame need telling apart
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			in_frame <= 1'b0;
			rd_dir   <= 1'b0;
			bit_n    <= 4'h0;
			byte_n   <= 2'h0;
			shift    <= 8'h00;
		end else if (start_ev) begin
			in_frame <= 1'b1;
			bit_n    <= 4'h0;
			byte_n   <= 2'h0;
		end else if (stop_ev) begin
			in_frame <= 1'b0;
		end else if (rise_ev) begin
			shift <= {shift[6:0], sda};
			bit_n <= (bit_n == 4'h8) ? 4'h0 : bit_n + 4'h1;
			if (bit_n == 4'h8 && byte_n != 2'h3) begin
				byte_n <= byte_n + 2'h1;
			end
			if (byte_n == 2'h0 && bit_n == 4'h7) begin
				rd_dir <= sda;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);

	a_dev_low_change: assert property ($changed(dev_sda_oe) |-> !scl && !scl_q)
		else $error("client data line moved while clock high");
	a_ack_prompt: assert property (fall_ev && bit_n == 4'h8 && dev_rx |-> ##[1:8] dev_sda_oe)
		else $error("client ack late or missing");
	a_ack_sampled: assert property (rise_ev && bit_n == 4'h8 && dev_rx |-> dev_sda_oe && !sda)
		else $error("ack not low at ninth clock");
	a_ack_release: assert property (fall_ev && bit_n == 4'h0 && byte_n != 2'h0 && !rd_dir && dev_sda_oe
		|-> ##[1:8] !dev_sda_oe)
		else $error("client ack not released");
	a_read_release: assert property (rise_ev && bit_n == 4'h8 && byte_n != 2'h0 && rd_dir |-> !dev_sda_oe)
		else $error("client drives host ack slot");
	a_host_send_quiet: assert property (rise_ev && bit_n < 4'h8 && (byte_n == 2'h0 || !rd_dir)
		|-> !dev_sda_oe)
		else $error("client drives while host sends");
	a_nack_ends_read: assert property (fall_ev && bit_n == 4'h0 && byte_n > 2'h1 && rd_dir && shift[0]
		|-> !dev_sda_oe [*8])
		else $error("client kept sending after nack");
	a_idle_quiet: assert property (!in_frame |-> !dev_sda_oe)
		else $error("client drives outside a frame");
	// 400 kHz top rate at 100 MHz: rise to rise never under 250 core clocks
	a_scl_rate: assert property (rise_ev && per_cnt != 9'h000 |-> per_cnt >= 9'h0fa)
		else $error("link clock faster than the top rate");

	c_write_ack: cover property (rise_ev && bit_n == 4'h8 && byte_n == 2'h2 && !rd_dir && !sda);
	c_restart: cover property (start_ev && in_frame);
	c_read_nack: cover property (rise_ev && bit_n == 4'h8 && byte_n != 2'h0 && rd_dir && sda);
endmodule : tsc_link_props
`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
	import tsc_pkg::*;
;
	// bench link quarter: the client needs a few core clocks to answer, so it lasts 8 core clocks, 80 ns
	localparam int unsigned QB = 8;
	logic         core_clk_i = 1'b0;
	logic         resetn_i = 1'b0;
	logic         cmd_valid_i = 1'b0;
	tsc_kind_type cmd_kind_i = K_WRITE;
	logic [7:0]   cmd_reg_i = 8'h00;
	logic [7:0]   cmd_count_i = 8'h00;
	logic [7:0]   wr_data_i = 8'h00;
	logic         deepest_sleep_control_i = 1'b0;
	logic         timeout_b = 1'b0;
	logic         cmd_ready_o, wr_take_o, rd_valid_o, done_o, nack_o, wr_strobe_o, awake_o, awake_b, ack;
	logic [7:0]   rd_data_o, rd_data_i, rd_ptr_o, wr_addr_o, wr_data_o, exp_ptr;
	logic [7:0]   mem [256];
	logic [7:0]   model [256];
	logic [7:0]   wq [$];
	logic [7:0]   rq [$];
	logic [15:0]  sq [$];
	logic         saw_awake = 1'b0;
	int           num_errors = 0;
	int           samples_checked = 0;

	////////////////////////////////////////////////////////////////////////////////
	tsc_link_if tsc_link_if_inst ();
	tsc_link_if tsc_link_if_inst_b ();
	tsc_host tsc_host_inst (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .link(tsc_link_if_inst.host),
		.cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_kind_i(cmd_kind_i), .cmd_reg_i(cmd_reg_i),
		.cmd_count_i(cmd_count_i), .wr_data_i(wr_data_i), .wr_take_o(wr_take_o), .rd_data_o(rd_data_o),
		.rd_valid_o(rd_valid_o), .done_o(done_o), .nack_o(nack_o));
	tsc_client tsc_client_inst (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .link(tsc_link_if_inst.dev),
		.timeout_en_i(timeout_b), .deepest_sleep_control_i(deepest_sleep_control_i), .rd_data_i(rd_data_i),
		.rd_ptr_o(rd_ptr_o), .wr_strobe_o(wr_strobe_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
		.awake_o(awake_o));
	// second client with short timeouts, its host lines driven by the bench
	tsc_client #(.LOW_CYCLES(200), .IDLE_CYCLES(50)) tsc_client_inst_b (.core_clk_i(core_clk_i),
		.resetn_i(resetn_i), .link(tsc_link_if_inst_b.dev), .timeout_en_i(timeout_b),
		.deepest_sleep_control_i(1'b1), .rd_data_i(8'h00), .rd_ptr_o(), .wr_strobe_o(), .wr_addr_o(),
		.wr_data_o(), .awake_o(awake_b));
	tsc_link_props tsc_link_props_inst (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
		.dev_sda_oe(tsc_link_if_inst.dev_sda_oe), .scl(tsc_link_if_inst.scl), .sda(tsc_link_if_inst.sda));

	always #5 core_clk_i = ~core_clk_i;
	assign rd_data_i = mem[rd_ptr_o];

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] expected);
		samples_checked++;
		if (seen !== expected) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, expected);
		end
	endtask : check

	task automatic final_report;
		$display("checked %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : final_report

	always @(posedge core_clk_i) begin
		if (wr_strobe_o === 1'b1) begin
			mem[wr_addr_o] <= wr_data_o;
			if (sq.size() == 0) check(16'h0001, 16'h0000);
			else check({wr_addr_o, wr_data_o}, sq.pop_front());
		end
		if (rd_valid_o === 1'b1) begin
			if (rq.size() == 0) check(16'h0001, 16'h0000);
			else check(16'(rd_data_o), 16'(rq.pop_front()));
		end
		if (wr_take_o === 1'b1) wr_data_i <= (wq.size() != 0) ? wq.pop_front() : 8'h00;
		if (awake_o === 1'b1) saw_awake <= 1'b1;
	end

	task automatic run_cmd(input tsc_kind_type kind, input logic [7:0] rg, input logic [7:0] cnt);
		int n;
		@(posedge core_clk_i);
		cmd_valid_i <= 1'b1;
		cmd_kind_i  <= kind;
		cmd_reg_i   <= rg;
		cmd_count_i <= cnt;
		do @(posedge core_clk_i); while (cmd_ready_o !== 1'b1);
		cmd_valid_i <= 1'b0;
		n = 0;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (done_o !== 1'b1 && n < 40000);
		check(16'(done_o), 16'h0001);
		check(16'(nack_o), 16'h0000);
	endtask : run_cmd

	task automatic do_write(input logic [7:0] rg, input int cnt);
		logic [7:0] d;
		exp_ptr = rg;
		for (int i = 0; i < cnt; i++) begin
			d = 8'($urandom);
			if (i == 0) wr_data_i <= d;
			else wq.push_back(d);
			sq.push_back({exp_ptr, d});
			model[exp_ptr] = d;
			exp_ptr++;
		end
		run_cmd(K_WRITE, rg, 8'(cnt));
		check(16'(rd_ptr_o), 16'(exp_ptr));
	endtask : do_write

	task automatic do_read(input tsc_kind_type kind, input logic [7:0] rg, input int cnt);
		if (kind == K_READ) exp_ptr = rg;
		for (int i = 0; i < cnt; i++) begin
			rq.push_back(model[exp_ptr]);
			if (i < cnt - 1) exp_ptr++;
		end
		run_cmd(kind, rg, 8'(cnt));
		check(16'(rd_ptr_o), 16'(exp_ptr));
	endtask : do_read

	task automatic bline(input logic pull_scl, input logic pull_sda);
		@(posedge core_clk_i);
		tsc_link_if_inst_b.host_scl_oe <= pull_scl;
		tsc_link_if_inst_b.host_sda_oe <= pull_sda;
		repeat (QB - 1) @(posedge core_clk_i);
	endtask : bline

	task automatic bstart;
		bline(1'b1, 1'b0);
		bline(1'b0, 1'b0);
		bline(1'b0, 1'b1);
		bline(1'b1, 1'b1);
	endtask : bstart

	task automatic bbyte(input logic [8:0] b);
		for (int i = 8; i >= 0; i--) begin
			bline(1'b1, !b[i]);
			bline(1'b0, !b[i]);
			ack = tsc_link_if_inst_b.sda;
			bline(1'b1, !b[i]);
		end
	endtask : bbyte

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		tsc_link_if_inst_b.host_scl_o = 1'b0;
		tsc_link_if_inst_b.host_sda_o = 1'b0;
		tsc_link_if_inst_b.host_scl_oe = 1'b0;
		tsc_link_if_inst_b.host_sda_oe = 1'b0;
		void'($urandom(32'h1f4c_bb11));
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'($urandom);
			model[i] = mem[i];
		end
		repeat (5) @(posedge core_clk_i);
		resetn_i <= 1'b1;
		@(posedge core_clk_i);
		check({7'h00, cmd_ready_o, rd_ptr_o}, 16'h0100);
		do_write(8'hfe, 3);
		do_write(8'($urandom), 1);
		run_cmd(K_SEND, 8'h40, 8'h01);
		exp_ptr = 8'h40;
		check(16'(rd_ptr_o), 16'h0040);
		do_read(K_RECV, 8'h00, 1);
		do_read(K_RECV, 8'h00, 1);
		do_read(K_READ, 8'hfe, 3);
		do_read(K_READ, 8'($urandom), 1);
		// deep sleep: reading without a pointer phase still works here
		deepest_sleep_control_i <= 1'b1;
		saw_awake = 1'b0;
		do_read(K_RECV, 8'h00, 1);
		check({15'h0000, saw_awake}, 16'h0001);
		check(16'(awake_o), 16'h0000);
		deepest_sleep_control_i <= 1'b0;
		check(16'(rq.size() + sq.size()), 16'h0000);
		bstart;
		bbyte({7'h29, 1'b0, 1'b1});
		check(16'(ack), 16'h0001);
		bbyte({7'h28, 1'b0, 1'b1});
		check(16'(ack), 16'h0001);
		bstart;
		bbyte({7'h28, 1'b0, 1'b1});
		check({15'h0000, ack}, 16'h0000);
		check(16'(awake_b), 16'h0001);
		repeat (300) @(posedge core_clk_i);
		check(16'(awake_b), 16'h0001);
		bline(1'b1, 1'b1);
		bline(1'b0, 1'b1);
		bline(1'b0, 1'b0);
		check(16'(awake_b), 16'h0000);
		timeout_b <= 1'b1;
		bstart;
		bbyte({7'h28, 1'b1, 1'b1});
		repeat (230) @(posedge core_clk_i);
		check(16'(awake_b), 16'h0000);
		bstart;
		bbyte({7'h28, 1'b0, 1'b1});
		check({15'h0000, ack}, 16'h0000);
		bline(1'b1, 1'b0);
		check(16'(awake_b), 16'h0001);
		bline(1'b0, 1'b0);
		repeat (60) @(posedge core_clk_i);
		check(16'(awake_b), 16'h0000);
		final_report;
	end

	initial begin
		// the whole sequence needs about 65,000 core clocks; stop at 90,000
		#900_000;
		num_errors++;
		final_report;
	end
endmodule : testbench
`default_nettype wire
